//--- rtl/irq_entry_pkg.sv
// What this block does
// - Source events set their own pending flag
// - Flags gated by enables, ORed to master
// - Master request qualified by global enable
// - Selected pins raise requests on level change
// - Finish instruction, push next address, branch
// - Entry clears the global enable
// - Return pops address, sets global enable
// - Nibble swap to file or working register
// - Nibble swap leaves status flags alone
// - File move may update zero flag
// - Top 16 bytes shared across all banks
`default_nettype none
package irq_entry_pkg;
  // ----------------------------------------
  // Sizes and fixed addresses
  // ----------------------------------------
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SHARED_BYTES = 16;
  localparam int unsigned SHARED_AW = 4;
  localparam logic [PC_W-1:0] SERVICE_VECTOR = 13'h0004;
  localparam logic [6:0] SHARED_BASE = 7'h70;
  localparam logic GLOBAL_EN_RST = 1'b0;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam int unsigned ZERO_BIT = 2;
  // ----------------------------------------
  // Operation codes from the sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SWAP = 3'h1,
    OP_MOVE = 3'h2,
    OP_RETURN = 3'h3,
    OP_WRITE = 3'h4
  } op_t;
  // Sequencer states, Gray along idle-push-branch
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PUSH = 2'b01,
    ST_BRANCH = 2'b11
  } seq_t;
endpackage : irq_entry_pkg
`default_nettype wire

//--- rtl/shared_scratch.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Unbanked scratch bytes
// ----------------------------------------
module shared_scratch #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [3:0] i_idx,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  // Storage, index is the low address bits only
  logic [7:0] mem_ff [DEPTH];
  // Write port
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= 8'h00;
    end
    else if (i_we)
    begin
      mem_ff[i_idx] <= i_wdata;
    end
  end
  // Read port is combinational; the top registers it
  assign o_rdata = mem_ff[i_idx];
endmodule : shared_scratch
`default_nettype wire

//--- rtl/irq_combine_and_entry.sv
`timescale 1ns/10ps
`default_nettype none
module irq_combine_and_entry #(
  parameter int unsigned N_SRC = 8,
  parameter int unsigned N_PIN = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [N_SRC-1:0] i_src_event,    // Peripheral event pulses
  input wire logic [N_SRC-1:0] i_src_enable,   // Per-source enables
  input wire logic [N_SRC-1:0] i_flag_clear,   // Software clear of flags
  input wire logic [N_PIN-1:0] i_pin,          // Monitored pins
  input wire logic [N_PIN-1:0] i_pin_select,   // Pins allowed to interrupt
  input wire logic i_pin_enable,               // Enable of pin-change flag
  input wire logic i_pin_flag_clear,
  input wire logic i_global_en_set,            // Software write of enable
  input wire logic i_global_en_clr,
  input wire logic i_instr_done,               // Current instruction ends
  input wire logic [irq_entry_pkg::PC_W-1:0] i_next_pc,
  input wire logic [2:0] i_op,                 // Operation from sequencer
  input wire logic i_dest_file,                // 1: result to file
  input wire logic [1:0] i_bank_select,        // bank_select_high/low
  input wire logic [6:0] i_file_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_file_rdata,         // Banked file read data
  output logic [N_SRC-1:0] o_pending,
  output logic o_pin_pending,
  output logic o_global_en,
  output logic o_irq_taken,                    // One-cycle pulse on entry
  output logic o_pc_load,
  output logic [irq_entry_pkg::PC_W-1:0] o_pc,
  output logic [7:0] o_work,
  output logic [7:0] o_status,
  output logic [7:0] o_file_wdata,
  output logic o_file_we,
  output logic o_stack_overflow
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    swap_nib = {v[3:0], v[7:4]};
  endfunction : swap_nib
  function automatic logic is_shared(input logic [6:0] a);
    is_shared = (a >= irq_entry_pkg::SHARED_BASE);
  endfunction : is_shared

  logic [N_SRC-1:0] pend_ff;
  logic pin_pend_ff;
  logic [N_PIN-1:0] pin_last_ff;
  logic pin_ref_ok_ff;                         // Pin reference captured
  logic global_en_ff;                          // Global interrupt enable
  logic master;
  logic qualified;
  irq_entry_pkg::seq_t state_ff;
  logic [irq_entry_pkg::PC_W-1:0] stack_ff [irq_entry_pkg::STACK_DEPTH];
  logic [3:0] sp_ff;                           // Entries in use
  logic [irq_entry_pkg::PC_W-1:0] ret_ff;      // Address being pushed
  logic [7:0] shared_rd;
  logic [7:0] src_data;
  logic is_ret;
  logic taken;

  // ----------------------------------------
  // Pending flags; set wins over clear
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pend_ff <= '0;
    else
      pend_ff <= (pend_ff & ~i_flag_clear) | i_src_event;
  end

  // Pin-change detect; the first edge after reset only captures the reference,
  // so a pin idling high gives no false flag (a change in that cycle is lost)
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_last_ff <= '0;
      pin_ref_ok_ff <= 1'b0;
      pin_pend_ff <= 1'b0;
    end
    else
    begin
      pin_last_ff <= i_pin;
      pin_ref_ok_ff <= 1'b1;
      pin_pend_ff <= (pin_pend_ff & ~i_pin_flag_clear)
                   | (pin_ref_ok_ff & (|((pin_last_ff ^ i_pin) & i_pin_select)));
    end
  end

  // ----------------------------------------
  // Request combining
  // ----------------------------------------
  assign master = |(pend_ff & i_src_enable) | (pin_pend_ff & i_pin_enable);
  assign qualified = master & global_en_ff;
  assign taken = qualified & i_instr_done & (state_ff == irq_entry_pkg::ST_RUN);
  assign is_ret = (i_op == 3'(irq_entry_pkg::OP_RETURN)) &&
                  (state_ff == irq_entry_pkg::ST_RUN) && !taken;

  // ----------------------------------------
  // Global enable; hardware entry clear wins
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      global_en_ff <= irq_entry_pkg::GLOBAL_EN_RST;
    else if (taken)
      global_en_ff <= 1'b0;
    else if (is_ret || i_global_en_set)
      global_en_ff <= 1'b1;
    else if (i_global_en_clr)
      global_en_ff <= 1'b0;
  end

  // ----------------------------------------
  // Entry sequencer: wait for instruction end, push, branch
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff <= irq_entry_pkg::ST_RUN;
      ret_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        irq_entry_pkg::ST_RUN:
        begin
          if (taken)
          begin
            ret_ff <= i_next_pc;
            state_ff <= irq_entry_pkg::ST_PUSH;
          end
        end
        irq_entry_pkg::ST_PUSH: state_ff <= irq_entry_pkg::ST_BRANCH;
        irq_entry_pkg::ST_BRANCH: state_ff <= irq_entry_pkg::ST_RUN;
        default: state_ff <= irq_entry_pkg::ST_RUN;
      endcase
    end
  end

  // Return stack; when full, sp holds at the depth and each further push overwrites entry 0 and sets overflow
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sp_ff <= '0;
      o_stack_overflow <= 1'b0;
      for (int i = 0; i < irq_entry_pkg::STACK_DEPTH; i++) stack_ff[i] <= '0;
    end
    else if (state_ff == irq_entry_pkg::ST_PUSH)
    begin
      stack_ff[sp_ff[2:0]] <= ret_ff;
      if (sp_ff == 4'(irq_entry_pkg::STACK_DEPTH))
        o_stack_overflow <= 1'b1;
      else
        sp_ff <= sp_ff + 4'h1;
    end
    else if (is_ret && sp_ff != 4'h0)
      sp_ff <= sp_ff - 4'h1;
  end

  // Program counter load: vector on entry, popped address on return
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pc_load <= 1'b0;
      o_pc <= '0;
      o_irq_taken <= 1'b0;
    end
    else
    begin
      o_irq_taken <= (state_ff == irq_entry_pkg::ST_BRANCH);
      o_pc_load <= (state_ff == irq_entry_pkg::ST_BRANCH) || is_ret;
      if (state_ff == irq_entry_pkg::ST_BRANCH)
        o_pc <= irq_entry_pkg::SERVICE_VECTOR;
      else if (is_ret)
        o_pc <= stack_ff[3'(sp_ff - 4'h1)];
    end
  end

  // ----------------------------------------
  // Data path: swap, move, shared scratch
  // ----------------------------------------
  shared_scratch #(
    .DEPTH(irq_entry_pkg::SHARED_BYTES)
  ) u_scratch (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_we((i_op == 3'(irq_entry_pkg::OP_WRITE) ||
           (i_op == 3'(irq_entry_pkg::OP_SWAP) && i_dest_file)) &&
          is_shared(i_file_addr)),
    .i_idx(i_file_addr[3:0]),
    .i_wdata((i_op == 3'(irq_entry_pkg::OP_SWAP)) ? swap_nib(shared_rd) : i_wdata),
    .o_rdata(shared_rd)
  );
  // Shared range ignores bank_select bits entirely
  assign src_data = is_shared(i_file_addr) ? shared_rd : i_file_rdata;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_work <= 8'h00;
      o_status <= irq_entry_pkg::STATUS_RST;
      o_file_wdata <= 8'h00;
      o_file_we <= 1'b0;
    end
    else
    begin
      o_file_we <= 1'b0;
      o_status[6:5] <= i_bank_select;
      if (i_op == 3'(irq_entry_pkg::OP_SWAP))
      begin
        // Status untouched here, so restored flags survive
        if (i_dest_file)
        begin
          o_file_wdata <= swap_nib(src_data);
          o_file_we <= !is_shared(i_file_addr);
        end
        else
          o_work <= swap_nib(src_data);
      end
      else if (i_op == 3'(irq_entry_pkg::OP_MOVE))
      begin
        o_work <= src_data;
        o_status[irq_entry_pkg::ZERO_BIT] <= (src_data == 8'h00);
      end
      else if (i_op == 3'(irq_entry_pkg::OP_WRITE) && !is_shared(i_file_addr))
      begin
        o_file_wdata <= i_wdata;
        o_file_we <= 1'b1;
      end
    end
  end

  // Flag views
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pending <= '0;
      o_pin_pending <= 1'b0;
      o_global_en <= 1'b0;
    end
    else
    begin
      o_pending <= pend_ff;
      o_pin_pending <= pin_pend_ff;
      o_global_en <= global_en_ff;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_entry;
    state_ff == irq_entry_pkg::ST_PUSH ##1 state_ff == irq_entry_pkg::ST_BRANCH;
  endsequence
  AST_ENTRY_SEQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    taken |=> s_entry ##1 (o_pc_load && o_pc == irq_entry_pkg::SERVICE_VECTOR))
    else $error("entry did not reach vector");
  AST_GLOBAL_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    taken |=> !global_en_ff) else $error("global enable not cleared");
  AST_RET_GLOBAL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    is_ret |=> global_en_ff ##1 o_global_en) else $error("return did not enable");
  AST_NO_TAKE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !global_en_ff |-> !taken) else $error("taken while disabled");
  AST_PEND_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_src_event != '0) |=> ((pend_ff & $past(i_src_event)) == $past(i_src_event))
    ##1 ((o_pending & $past(i_src_event, 2)) == $past(i_src_event, 2)))
    else $error("flag not set");
  AST_MASTER: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ((pend_ff & i_src_enable) != '0) |-> master) else $error("master missing");
  AST_SWAP_STAT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_op == 3'(irq_entry_pkg::OP_SWAP) |=> o_status[4:0] == $past(o_status[4:0]))
    else $error("swap changed status");
  AST_PIN_CHG: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (pin_ref_ok_ff && (((i_pin ^ $past(i_pin)) & i_pin_select) != '0)) |=> pin_pend_ff)
    else $error("pin change lost");
endmodule : irq_combine_and_entry
`default_nettype wire

//--- verification/banked_file_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Banked file store behind the core
// ----------------------------------------
module banked_file_model (
  input wire logic i_clk,
  input wire logic [1:0] i_bank,   // Bank bits of the access
  input wire logic [6:0] i_addr,   // Offset inside the bank
  input wire logic i_we,           // Registered write strobe
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:511];         // Four banks of 128 bytes
  // Known contents so a stray read never shows an unknown
  initial
  begin
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = i[7:0];
    end
  end
  // Writes land on the strobe; address is held by the driver meanwhile
  always @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[{i_bank, i_addr}] <= i_wdata;
    end
  end
  // Shared top is not stored here: a bank-dependent pattern exposes a wrong path
  assign o_rdata = (i_addr >= 7'h70) ? {i_bank, ~i_addr[5:0]} : mem[{i_bank, i_addr}];
endmodule : banked_file_model
`default_nettype wire

//--- verification/irq_combine_and_entry_tb.sv
`timescale 1ns/10ps
`default_nettype none
module irq_combine_and_entry_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic i_clk, i_rstn, i_pin_enable, i_pin_flag_clear, i_global_en_set, i_global_en_clr;
  logic [7:0] i_src_event, i_src_enable, i_flag_clear, i_wdata, i_file_rdata;
  logic [3:0] i_pin, i_pin_select;
  logic i_instr_done, i_dest_file, o_pin_pending, o_global_en, o_irq_taken, o_pc_load;
  logic [12:0] i_next_pc, o_pc;
  logic [2:0] i_op;
  logic [1:0] i_bank_select;
  logic [6:0] i_file_addr;
  logic [7:0] o_pending, o_work, o_status, o_file_wdata;
  logic o_file_we, o_stack_overflow;
  int n_mismatch = 0;
  int samples_checked = 0;
  // 10 MHz clock
  always #50 i_clk = ~i_clk;
  irq_combine_and_entry u_irq_combine_and_entry (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_src_event(i_src_event), .i_src_enable(i_src_enable), .i_flag_clear(i_flag_clear),
    .i_pin(i_pin), .i_pin_select(i_pin_select), .i_pin_enable(i_pin_enable),
    .i_pin_flag_clear(i_pin_flag_clear), .i_global_en_set(i_global_en_set),
    .i_global_en_clr(i_global_en_clr), .i_instr_done(i_instr_done), .i_next_pc(i_next_pc),
    .i_op(i_op), .i_dest_file(i_dest_file), .i_bank_select(i_bank_select),
    .i_file_addr(i_file_addr), .i_wdata(i_wdata), .i_file_rdata(i_file_rdata),
    .o_pending(o_pending), .o_pin_pending(o_pin_pending), .o_global_en(o_global_en),
    .o_irq_taken(o_irq_taken), .o_pc_load(o_pc_load), .o_pc(o_pc), .o_work(o_work),
    .o_status(o_status), .o_file_wdata(o_file_wdata), .o_file_we(o_file_we),
    .o_stack_overflow(o_stack_overflow));
  banked_file_model u_banked_file_model (.i_clk(i_clk), .i_bank(i_bank_select),
    .i_addr(i_file_addr), .i_we(o_file_we), .i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Compare one value, at most 16 bits wide
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle sequencer operation; address and bank stay put for the late write strobe
  task automatic do_op(input logic [2:0] op, input logic dst, input logic [1:0] bank,
                       input logic [6:0] addr, input logic [7:0] wd);
    @(posedge i_clk);
    i_op <= op;
    i_dest_file <= dst;
    i_bank_select <= bank;
    i_file_addr <= addr;
    i_wdata <= wd;
    @(posedge i_clk);
    i_op <= 3'h0;
    repeat (3) @(negedge i_clk);
  endtask : do_op
  // Bounded wait for a program counter load, then judge it
  task automatic wait_load(input logic [12:0] pc, input logic irq);
    int k;
    k = 0;
    while (o_pc_load !== 1'b1 && k < 20)
    begin
      @(negedge i_clk);
      k++;
    end
    chk("pc_load", 16'h1, {15'h0, o_pc_load});
    chk("pc", {3'h0, pc}, {3'h0, o_pc});
    chk("irq_taken", {15'h0, irq}, {15'h0, o_irq_taken});
  endtask : wait_load
  // No entry may start within the span
  task automatic no_load(input string what);
    logic seen;
    seen = 1'b0;
    repeat (10)
    begin
      @(negedge i_clk);
      seen = seen | o_pc_load;
    end
    chk(what, 16'h0, {15'h0, seen});
  endtask : no_load
  // Pulse single-cycle software strobes
  task automatic pulse(input logic set, input logic clr, input logic pin_clr,
                       input logic [7:0] flags);
    @(posedge i_clk);
    i_global_en_set <= set;
    i_global_en_clr <= clr;
    i_pin_flag_clear <= pin_clr;
    i_flag_clear <= flags;
    @(posedge i_clk);
    i_global_en_set <= 1'b0;
    i_global_en_clr <= 1'b0;
    i_pin_flag_clear <= 1'b0;
    i_flag_clear <= 8'h00;
  endtask : pulse
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Gated flag, then global gate, then a real entry
  task automatic t_entry();
    @(posedge i_clk);
    i_next_pc <= 13'h0123;
    i_src_event <= 8'h04;
    @(posedge i_clk);
    i_src_event <= 8'h00;
    pulse(1'b1, 1'b0, 1'b0, 8'h00);
    no_load("masked source");
    chk("pending", 16'h04, {8'h0, o_pending});
    pulse(1'b0, 1'b1, 1'b0, 8'h00);
    @(posedge i_clk);
    i_src_enable <= 8'h04;
    no_load("global off");
    pulse(1'b1, 1'b0, 1'b0, 8'h00);
    wait_load(irq_entry_pkg::SERVICE_VECTOR, 1'b1);
    chk("global_en", 16'h0, {15'h0, o_global_en});
  endtask : t_entry
  // Service routine polls, clears its flag and returns
  task automatic t_return();
    chk("poll", 16'h04, {8'h0, o_pending});
    pulse(1'b0, 1'b0, 1'b0, 8'h04);
    repeat (2) @(negedge i_clk);
    chk("cleared", 16'h0, {8'h0, o_pending});
    @(posedge i_clk);
    i_op <= 3'h3;
    @(posedge i_clk);
    i_op <= 3'h0;
    wait_load(13'h0123, 1'b0);
    @(negedge i_clk);
    chk("global_en", 16'h1, {15'h0, o_global_en});
    chk("stack overflow", 16'h0, {15'h0, o_stack_overflow});
  endtask : t_return
  // Only selected pins raise the pin-change flag
  task automatic t_pin();
    pulse(1'b0, 1'b1, 1'b0, 8'h00);
    i_pin_select <= 4'h2;
    i_pin_enable <= 1'b1;
    i_pin <= 4'h1;
    repeat (3) @(negedge i_clk);
    chk("pin unselected", 16'h0, {15'h0, o_pin_pending});
    @(posedge i_clk);
    i_pin <= 4'h3;
    repeat (3) @(negedge i_clk);
    chk("pin selected", 16'h1, {15'h0, o_pin_pending});
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
  endtask : t_pin
  // Move, swap both ways, and the shared top bytes
  task automatic t_data();
    do_op(3'h4, 1'b1, 2'h1, 7'h20, 8'h00);
    do_op(3'h2, 1'b0, 2'h1, 7'h20, 8'h00);
    chk("zero move", 16'h3c, {8'h0, o_status});
    do_op(3'h4, 1'b1, 2'h1, 7'h21, 8'h3c);
    do_op(3'h1, 1'b0, 2'h1, 7'h21, 8'h00);
    chk("swap to work", 16'hc3, {8'h0, o_work});
    chk("swap status", 16'h3c, {8'h0, o_status});
    do_op(3'h1, 1'b1, 2'h1, 7'h21, 8'h00);
    chk("swap to file", 16'hc3, {8'h0, o_file_wdata});
    do_op(3'h2, 1'b0, 2'h1, 7'h21, 8'h00);
    chk("move status", 16'h38, {8'h0, o_status});
    chk("file swap landed", 16'hc3, {8'h0, o_work});
    do_op(3'h4, 1'b1, 2'h0, 7'h75, 8'h69);
    do_op(3'h2, 1'b0, 2'h3, 7'h75, 8'h00);
    chk("shared byte", 16'h69, {8'h0, o_work});
  endtask : t_data
  // Service routine saves working then status, clobbers both, restores working by swaps
  task automatic t_context();
    do_op(3'h4, 1'b1, 2'h0, 7'h70, o_work);
    do_op(3'h4, 1'b1, 2'h0, 7'h71, o_status);
    do_op(3'h2, 1'b0, 2'h2, 7'h00, 8'h00);
    chk("clobbered zero", 16'h5c, {8'h0, o_status});
    do_op(3'h2, 1'b0, 2'h1, 7'h71, 8'h00);
    chk("status image", 16'h18, {8'h0, o_work});
    do_op(3'h1, 1'b1, 2'h1, 7'h70, 8'h00);
    do_op(3'h1, 1'b0, 2'h1, 7'h70, 8'h00);
    chk("work restored", 16'h69, {8'h0, o_work});
    chk("status kept", 16'h38, {8'h0, o_status});
  endtask : t_context
  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Whole run is well under two hundred cycles; this cuts a hang
  initial
  begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {i_clk, i_rstn, i_pin_enable, i_pin_flag_clear, i_global_en_set, i_global_en_clr} = '0;
    {i_src_event, i_src_enable, i_flag_clear, i_wdata, i_pin, i_pin_select} = '0;
    {i_next_pc, i_op, i_dest_file, i_bank_select, i_file_addr} = '0;
    i_instr_done = 1'b1;
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(negedge i_clk);
    chk("status reset", {8'h0, irq_entry_pkg::STATUS_RST}, {8'h0, o_status});
    chk("global reset", 16'h0, {15'h0, o_global_en});
    t_entry();
    t_return();
    t_pin();
    t_data();
    t_context();
    complete_run();
  end
endmodule : irq_combine_and_entry_tb
`default_nettype wire
